// ===== rtl/vpf_packet_formatter.v
// vbi packet formatter: wraps one sliced line into a fixed 56-byte packet
//
// How it works
// - every packet is exactly 56 bytes including start and end codes.
// - start and end codes built from field identity and configured bits.
// - a 4-byte internal header follows the start code, with ident bytes.
// - packet closes with byte count, then checksum, then end code.
// - bytes between last payload byte and byte count are stuffed A0.
// - 35-byte character-broadcast lines are packed like any other line.
// - first payload byte directly follows the header, nothing between.
// - packets leave on the image port video byte stream.
`include "vpf_map.vh"

module vpf_packet_formatter #(
    parameter PAY_MAX = 42,
    parameter AW = 6
) (
    // clock and reset
    input wire clk_sys,
    input wire resetn,
    // payload load port
    input wire load_en,
    input wire [AW-1:0] load_addr,
    input wire [7:0] load_data,
    // packet request
    input wire pkt_start,
    input wire [5:0] pkt_len,
    input wire [3:0] pkt_type,
    input wire [9:0] pkt_line,
    input wire pkt_field_odd,
    // configuration
    input wire [7:0] cfg_sdid,
    input wire cfg_vbit,
    // status
    output reg pkt_ready,
    // image port stream
    output reg [7:0] vid_data,
    output reg vid_valid,
    output reg vid_sop,
    output reg vid_eop
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN = 1'b1;

    reg state;
    reg next_state;
    reg [5:0] pos;
    reg [5:0] next_pos;
    reg [5:0] len;
    reg [7:0] header_ident_byte_one;
    reg [7:0] header_ident_byte_two;
    reg [7:0] sdid;
    reg field;
    reg vbit;
    reg [7:0] csum;
    reg [7:0] next_csum;
    reg [7:0] cur_byte;
    reg [AW-1:0] rd_addr;
    wire [7:0] rd_data;
    wire [5:0] pay_idx;
    wire take;

    assign take = (state == ST_IDLE) && pkt_ready && pkt_start;
    assign pay_idx = pos - `VPF_POS_PAY;

    // ------------------------------------------------------------------
    // payload store
    // ------------------------------------------------------------------
    always @* begin
        rd_addr = pay_idx[AW-1:0];
    end

    vpf_line_store #(
        .DEPTH(PAY_MAX),
        .AW(AW)
    ) u_store (
        .clk_sys(clk_sys),
        .wr_en(load_en && (state == ST_IDLE)),
        .wr_addr(load_addr),
        .wr_data(load_data),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    // ------------------------------------------------------------------
    // timing reference code: 1 F V H and protection bits
    // ------------------------------------------------------------------
    function [7:0] trs_code;
        input f;
        input v;
        input h;
        begin
            trs_code[`VPF_TRS_ONE_BIT] = 1'b1;
            trs_code[`VPF_TRS_F_BIT] = f;
            trs_code[`VPF_TRS_V_BIT] = v;
            trs_code[`VPF_TRS_H_BIT] = h;
            trs_code[3] = v ^ h;
            trs_code[2] = f ^ h;
            trs_code[1] = f ^ v;
            trs_code[0] = f ^ v ^ h;
        end
    endfunction

    // ------------------------------------------------------------------
    // byte selection by position
    // ------------------------------------------------------------------
    always @* begin
        cur_byte = `VPF_TRS_00;
        if (pos == 6'd0 || pos == `VPF_POS_EAV - 6'd3) begin
            cur_byte = `VPF_TRS_FF;
        end else if (pos == `VPF_POS_SAV) begin
            cur_byte = trs_code(field, vbit, 1'b0);
        end else if (pos == `VPF_POS_SDID) begin
            cur_byte = sdid;
        end else if (pos == `VPF_POS_DWC) begin
            cur_byte = `VPF_DWORD_CNT;
        end else if (pos == `VPF_POS_IDENT_ONE) begin
            cur_byte = header_ident_byte_one;
        end else if (pos == `VPF_POS_IDENT_TWO) begin
            cur_byte = header_ident_byte_two;
        end else if (pos >= `VPF_POS_PAY && pos < `VPF_POS_BC) begin
            // payload starts at the first slot after the header
            if (pay_idx < len) begin
                cur_byte = rd_data;
            end else begin
                cur_byte = `VPF_STUFF;
            end
        end else if (pos == `VPF_POS_BC) begin
            cur_byte = {2'b00, len};
        end else if (pos == `VPF_POS_CSUM) begin
            cur_byte = csum;
        end else if (pos == `VPF_POS_EAV) begin
            cur_byte = trs_code(field, vbit, 1'b1);
        end
    end

    // ------------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------------
    always @* begin
        next_state = state;
        next_pos = pos;
        next_csum = csum;
        case (state)
            ST_IDLE: begin
                if (take) begin
                    next_state = ST_RUN;
                    next_pos = 6'd0;
                    next_csum = 8'h00;
                end
            end
            ST_RUN: begin
                if (pos >= `VPF_POS_SDID && pos <= `VPF_POS_BC) begin
                    next_csum = csum + cur_byte;
                end
                if (pos == `VPF_PKT_LEN - 6'd1) begin
                    next_state = ST_IDLE;
                end else begin
                    next_pos = pos + 6'd1;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (!resetn) begin
            state <= ST_IDLE;
            pos <= 6'd0;
            csum <= 8'h00;
            len <= 6'd0;
            header_ident_byte_one <= 8'h00;
            header_ident_byte_two <= 8'h00;
            sdid <= 8'h00;
            field <= 1'b0;
            vbit <= 1'b0;
        end else begin
            state <= next_state;
            pos <= next_pos;
            csum <= next_csum;
            if (take) begin
                // lengths beyond the payload area are clipped
                if (pkt_len > `VPF_PAY_MAX) begin
                    len <= `VPF_PAY_MAX;
                end else begin
                    len <= pkt_len;
                end
                header_ident_byte_one <= {pkt_type, 2'b00, pkt_line[9:8]};
                header_ident_byte_two <= pkt_line[7:0];
                sdid <= cfg_sdid;
                field <= pkt_field_odd;
                vbit <= cfg_vbit;
            end
        end
    end

    // ------------------------------------------------------------------
    // registered image port outputs
    // ------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (!resetn) begin
            vid_data <= 8'h00;
            vid_valid <= 1'b0;
            vid_sop <= 1'b0;
            vid_eop <= 1'b0;
            pkt_ready <= 1'b0;
        end else begin
            vid_valid <= (state == ST_RUN);
            vid_data <= (state == ST_RUN) ? cur_byte : 8'h00;
            vid_sop <= (state == ST_RUN) && (pos == 6'd0);
            vid_eop <= (state == ST_RUN) && (pos == `VPF_POS_EAV);
            pkt_ready <= (next_state == ST_IDLE);
        end
    end

endmodule

// ===== inc/vpf_map.vh
// packet layout constants for the vbi packet formatter
`ifndef VPF_MAP_VH
`define VPF_MAP_VH

// ----------------------------------------------------------------------
// packet geometry (byte positions inside one packet)
// ----------------------------------------------------------------------
`define VPF_PKT_LEN 6'd56
`define VPF_POS_SAV 6'd3
`define VPF_POS_SDID 6'd4
`define VPF_POS_DWC 6'd5
`define VPF_POS_IDENT_ONE 6'd6
`define VPF_POS_IDENT_TWO 6'd7
`define VPF_POS_PAY 6'd8
`define VPF_POS_BC 6'd50
`define VPF_POS_CSUM 6'd51
`define VPF_POS_EAV 6'd55
`define VPF_PAY_MAX 6'd42

// ----------------------------------------------------------------------
// fixed byte values
// ----------------------------------------------------------------------
`define VPF_TRS_FF 8'hFF
`define VPF_TRS_00 8'h00
`define VPF_DWORD_CNT 8'h0B
`define VPF_STUFF 8'hA0
`define VPF_MOJI_LEN 6'd35

// ----------------------------------------------------------------------
// timing reference code fields
// ----------------------------------------------------------------------
`define VPF_TRS_ONE_BIT 7
`define VPF_TRS_F_BIT 6
`define VPF_TRS_V_BIT 5
`define VPF_TRS_H_BIT 4

`endif

// ===== rtl/vpf_line_store.v
// payload line store holding the sliced bytes of one line
module vpf_line_store #(
    parameter DEPTH = 42,
    parameter AW = 6
) (
    // clock
    input wire clk_sys,
    // write side
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [7:0] wr_data,
    // read side
    input wire [AW-1:0] rd_addr,
    output wire [7:0] rd_data
);

    reg [7:0] mem [0:DEPTH-1];

    always @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    assign rd_data = mem[rd_addr];

endmodule

// ===== tb/vpf_mon_monitor.sv
// checker on the packet formatter stream ports
module vpf_mon (
    // clock and reset
    input logic clk_sys,
    input logic resetn,
    // request and stream
    input logic pkt_start,
    input logic pkt_ready,
    input logic [7:0] vid_data,
    input logic vid_valid,
    input logic vid_sop,
    input logic vid_eop
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] idx;
    wire [5:0] pos = vid_sop ? 6'h00 : idx;
    wire [7:0] d = vid_data;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    always @(posedge clk_sys)
        if (!resetn) idx <= 6'h00;
        else idx <= vid_valid ? pos + 6'h01 : 6'h00;
    sequence s_take; pkt_start && pkt_ready; endsequence
    sequence s_open; ##2 vid_sop && vid_valid; endsequence
    sequence s_lead; d == 8'hFF ##1 d == 8'h00 ##1 d == 8'h00; endsequence
    take_open_a:
        assert property (s_take |-> s_open) else $error("no packet");
    fixed_len_a:
        assert property (vid_eop |-> vid_valid && pos == 6'h37)
        else $error("packet length wrong");
    end_gap_a:
        assert property (vid_eop |=> !vid_valid) else $error("no gap");
    lead_code_a:
        assert property (vid_sop |-> s_lead) else $error("bad lead");
    tail_pad_a:
        assert property (vid_valid && (pos == 6'h35 || pos == 6'h36)
            |-> d == 8'h00) else $error("bad end code pad");
    code_par_a:
        assert property (vid_valid && (pos == 6'h03 || pos == 6'h37)
            |-> d[7] && d[4] == (pos == 6'h37) && d[3:0] ==
            {d[5] ^ d[4], d[6] ^ d[4], d[6] ^ d[5], ^d[6:4]})
        else $error("bad timing code");
    word_cnt_a:
        assert property (vid_valid && pos == 6'h05 |-> d == 8'h0B)
        else $error("bad word count byte");
    idle_zero_a:
        assert property (!vid_valid |-> d == 8'h00) else $error("idle data");
    busy_low_a:
        assert property (vid_valid && !vid_eop |-> !pkt_ready)
        else $error("ready during packet");
endmodule

// ===== tb/vpf_sink.sv
// capture back end model taking packets off the stream
module vpf_sink (
    // clock and stream
    input logic clk_sys,
    input logic [7:0] vid_data,
    input logic vid_valid,
    input logic vid_sop,
    input logic vid_eop,
    // captured packet
    output logic [7:0] pkt [0:55],
    output int n_pkt,
    output int n_len
);
    timeunit 1ns;
    timeprecision 1ps;
    int k = 0;
    int n_seen = 0;
    int idx;
    assign n_pkt = n_seen;
    assign idx = vid_sop ? 0 : k;
    // bytes are taken from the video stream itself
    always @(posedge clk_sys) begin
        if (vid_valid) begin
            pkt[idx] <= vid_data;
            k <= idx + 1;
            if (vid_eop) begin
                n_seen <= n_seen + 1;
                n_len <= idx + 1;
            end
        end
    end
endmodule

// ===== tb/vbi_packet_formatter_bench.sv
// self-checking bench for the packet formatter
module vbi_packet_formatter_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic load_en = 1'b0;
    logic pkt_start = 1'b0;
    logic pkt_field_odd = 1'b0;
    logic cfg_vbit = 1'b0;
    logic [5:0] load_addr = 6'h00;
    logic [5:0] pkt_len = 6'h00;
    logic [7:0] load_data = 8'h00;
    logic [7:0] cfg_sdid = 8'h00;
    logic [3:0] pkt_type = 4'h0;
    logic [9:0] pkt_line = 10'h000;
    logic pkt_ready, vid_valid, vid_sop, vid_eop;
    logic [7:0] vid_data;
    logic [7:0] cap [0:55];
    logic [7:0] pay [0:41];
    int n_pkt, n_len;
    int n_errors = 0;
    int total_checks = 0;
    always #2 clk_sys = ~clk_sys;
    vpf_packet_formatter vpf_packet_formatter_i (.clk_sys(clk_sys),
        .resetn(resetn), .load_en(load_en), .load_addr(load_addr),
        .load_data(load_data), .pkt_start(pkt_start), .pkt_len(pkt_len),
        .pkt_type(pkt_type), .pkt_line(pkt_line),
        .pkt_field_odd(pkt_field_odd), .cfg_sdid(cfg_sdid),
        .cfg_vbit(cfg_vbit), .pkt_ready(pkt_ready), .vid_data(vid_data),
        .vid_valid(vid_valid), .vid_sop(vid_sop), .vid_eop(vid_eop));
    vpf_sink vpf_sink_i (.clk_sys(clk_sys), .vid_data(vid_data),
        .vid_valid(vid_valid), .vid_sop(vid_sop), .vid_eop(vid_eop),
        .pkt(cap), .n_pkt(n_pkt), .n_len(n_len));
    task stop_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input string what, input logic [7:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task tick();
        @(posedge clk_sys);
        #1;
    endtask
    task load(input int n, input logic [7:0] base);
        for (int k = 0; k < n; k++) begin
            pay[k] = base + 8'(k);
            load_en = 1'b1;
            load_addr = 6'(k);
            load_data = pay[k];
            tick();
        end
        load_en = 1'b0;
    endtask
    function automatic logic [7:0] trs(input logic f, v, h);
        return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
    endfunction
    task send(input logic [5:0] len, input logic [3:0] ty,
        input logic [9:0] ln, input logic f, v, input logic [7:0] sd);
        logic [7:0] e [0:55];
        logic [7:0] sum;
        int n0;
        int w;
        n0 = n_pkt;
        w = 0;
        while (pkt_ready !== 1'b1 && w < 99) begin
            tick();
            w++;
        end
        pkt_len = len;
        pkt_type = ty;
        pkt_line = ln;
        pkt_field_odd = f;
        cfg_vbit = v;
        cfg_sdid = sd;
        pkt_start = 1'b1;
        tick();
        pkt_start = 1'b0;
        if (len > 6'd42) len = 6'd42;
        e[0] = 8'hFF;
        e[1] = 8'h00;
        e[2] = 8'h00;
        e[3] = trs(f, v, 1'b0);
        e[4] = sd;
        e[5] = 8'h0B;
        e[6] = {ty, 2'b00, ln[9:8]};
        e[7] = ln[7:0];
        for (int i = 8; i < 50; i++) e[i] = (i - 8 < len) ? pay[i - 8] : 8'hA0;
        e[50] = {2'b00, len};
        sum = 8'h00;
        for (int i = 4; i < 51; i++) sum += e[i];
        e[51] = sum;
        e[52] = 8'hFF;
        e[53] = 8'h00;
        e[54] = 8'h00;
        e[55] = trs(f, v, 1'b1);
        while (n_pkt == n0 && w < 199) begin
            tick();
            w++;
        end
        chk("packet seen", 8'(n_pkt - n0), 8'h01);
        chk("length", 8'(n_len), 8'd56);
        for (int i = 0; i < 4; i++)
            chk($sformatf("byte%0d", i), cap[i], e[i]);
        for (int i = 4; i < 8; i++)
            chk($sformatf("byte%0d", i), cap[i], e[i]);
        chk("byte8", cap[8], e[8]);
        for (int i = 9; i < 50; i++)
            chk($sformatf("byte%0d", i), cap[i], e[i]);
        for (int i = 50; i < 52; i++)
            chk($sformatf("byte%0d", i), cap[i], e[i]);
        for (int i = 52; i < 56; i++)
            chk($sformatf("byte%0d", i), cap[i], e[i]);
    endtask
    task t_clip();
        load(42, 8'h10);
        send(6'd45, 4'h1, 10'h2A5, 1'b1, 1'b0, 8'h55);
        $display("test clip done");
    endtask
    task t_moji();
        load(35, 8'hE0);
        send(6'd35, 4'h7, 10'h014, 1'b0, 1'b1, 8'h3C);
        send(6'd1, 4'hF, 10'h3FF, 1'b1, 1'b1, 8'hC3);
        $display("test moji done");
    endtask
    task t_refuse();
        fork
            send(6'd2, 4'h2, 10'h001, 1'b0, 1'b0, 8'h00);
            begin
                repeat (20) tick();
                pkt_start = 1'b1;
                load_en = 1'b1;
                load_data = 8'h5A;
                load_addr = 6'h00;
                tick();
                pkt_start = 1'b0;
                load_en = 1'b0;
            end
        join
        repeat (70) tick();
        chk("packets", 8'(n_pkt), 8'd4);
        send(6'd1, 4'h3, 10'h100, 1'b1, 1'b0, 8'hFF);
        $display("test refuse done");
    endtask
    task t_reset();
        pkt_start = 1'b1;
        tick();
        pkt_start = 1'b0;
        repeat (10) tick();
        resetn = 1'b0;
        repeat (2) tick();
        chk("valid in reset", {7'h00, vid_valid}, 8'h00);
        chk("ready in reset", {7'h00, pkt_ready}, 8'h00);
        resetn = 1'b1;
        tick();
        chk("ready after reset", {7'h00, pkt_ready}, 8'h01);
        send(6'd2, 4'h4, 10'h0C3, 1'b0, 1'b1, 8'h81);
        $display("test reset done");
    endtask
    initial begin
        repeat (2) tick();
        resetn = 1'b1;
        tick();
        t_clip();
        t_moji();
        t_refuse();
        t_reset();
        stop_test();
    end
    initial begin
        #20000;
        n_errors++;
        stop_test();
    end
endmodule
bind vpf_packet_formatter vpf_mon vpf_mon_i (.clk_sys(clk_sys),
    .resetn(resetn), .pkt_start(pkt_start), .pkt_ready(pkt_ready),
    .vid_data(vid_data), .vid_valid(vid_valid), .vid_sop(vid_sop),
    .vid_eop(vid_eop));
